// ---- shared/sdf_pkg.sv ----
/*
 * Constants and types shared by the delta-sigma decimation filter.
 * Assumes a single 20 MHz clock domain with a synchronous active-high reset.
 */
`default_nettype none
package sdf_pkg;
    // Main clock cycles per modulator sample.
    localparam int MOD_DIV = 2;
    localparam int SEL_W = 3;
    // Smallest ratio is 2**7 = 128, largest 2**14 = 16384.
    localparam int RATIO_MIN_LOG2 = 7;
    localparam int RATIO_MAX_LOG2 = 14;
    // Largest decimation of the third-order stage is 2**10 = 1024.
    localparam int S3_MAX_LOG2 = 10;
    localparam int FAST_CONVS = 2;
    localparam int ACC_W = 32;
    localparam int FRAC_W = 24;
    localparam int DATA_W = FRAC_W + 1;
    localparam int FIFO_DEPTH = 8;
    localparam int CLOCK_HZ = 20000000;
    localparam logic [SEL_W-1:0] SEL_RST = 3'h0;
    localparam logic [1:0] CONV_CNT_RST = 2'h0;
    // Settling time in modulator periods for each rate_ratio_sel code.
    localparam int SETTLE_MOD [8] = '{432, 816, 1584, 3120, 6192, 10288, 18480, 34864};

    typedef enum logic [0:0] {
        SDF_FAST = 1'b0,
        SDF_SINC3 = 1'b1
    } sdf_path_t;
endpackage
`default_nettype wire

// ---- hw/sdf_filter.sv ----
/*
 * Decimation filter for one delta-sigma channel, with its output FIFO.
 * Assumes the modulator bit is produced on the same clock and is sampled on mod_clk_en.
 * The host side drains results with valid/ready and must handle settling itself.
 */
`timescale 1ns/100ps
`default_nettype none

module sdf_fifo #(
    parameter int WIDTH = sdf_pkg::DATA_W + 1,
    parameter int DEPTH = sdf_pkg::FIFO_DEPTH
) (
    input wire logic clock,
    input wire logic srst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    // DEPTH must be a power of two so that the pointers wrap on their own.
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [AW-1:0] wr_ff;
    logic [AW-1:0] nxt_wr;
    logic [AW-1:0] rd_ff;
    logic [AW-1:0] nxt_rd;
    logic [AW:0] cnt_ff;
    logic [AW:0] nxt_cnt;
    logic push;
    logic pop;

    always_comb begin
        in_ready = cnt_ff != (AW+1)'(DEPTH);
        out_valid = cnt_ff != '0;
        push = in_valid && in_ready;
        pop = out_valid && out_ready;
        nxt_wr = push ? AW'(wr_ff + 1'b1) : wr_ff;
        nxt_rd = pop ? AW'(rd_ff + 1'b1) : rd_ff;
        nxt_cnt = (AW+1)'(cnt_ff + (AW+1)'(push) - (AW+1)'(pop));
    end

    assign out_data = mem_ff[rd_ff];

    always_ff @(posedge clock) begin
        if (srst) begin
            wr_ff <= '0;
            rd_ff <= '0;
            cnt_ff <= '0;
        end else begin
            wr_ff <= nxt_wr;
            rd_ff <= nxt_rd;
            cnt_ff <= nxt_cnt;
        end
        if (push) begin
            mem_ff[wr_ff] <= in_data;
        end
    end
endmodule

module sdf_filter (
    input wire logic clock,
    input wire logic srst,
    input wire logic mod_bitstream,
    input wire logic [sdf_pkg::SEL_W-1:0] rate_ratio_sel,
    input wire logic restart,
    output logic mod_clk_en,
    output logic [sdf_pkg::DATA_W-1:0] result_data,
    output logic result_fast,
    output logic result_valid,
    input wire logic result_ready,
    output logic data_ready_n,
    output logic overrun
);
    localparam int CNT_W = sdf_pkg::RATIO_MAX_LOG2;
    localparam int ACC_W = sdf_pkg::ACC_W;
    localparam int DATA_W = sdf_pkg::DATA_W;
    localparam int PST_W = DATA_W + sdf_pkg::RATIO_MAX_LOG2 - sdf_pkg::S3_MAX_LOG2;
    localparam int WIDE_W = ACC_W + sdf_pkg::FRAC_W;
    localparam int DIV_W = $clog2(sdf_pkg::MOD_DIV);

    logic [DIV_W-1:0] div_ff;
    logic [DIV_W-1:0] nxt_div;
    logic [sdf_pkg::SEL_W-1:0] sel_ff;
    logic [CNT_W-1:0] ncnt_ff;
    logic [CNT_W-1:0] nxt_ncnt;
    logic [ACC_W-1:0] i1_ff, i2_ff, i3_ff, d1_ff, d2_ff, d3_ff;
    logic [ACC_W-1:0] nxt_i1, nxt_i2, nxt_i3, nxt_d1, nxt_d2, nxt_d3;
    logic [ACC_W-1:0] x, c1, c2, c3;
    logic [CNT_W:0] fsum_ff;
    logic [CNT_W:0] nxt_fsum;
    logic [CNT_W:0] fsum_tot;
    logic [PST_W-1:0] pacc_ff;
    logic [PST_W-1:0] nxt_pacc;
    logic [PST_W-1:0] psum;
    sdf_pkg::sdf_path_t path_ff;
    sdf_pkg::sdf_path_t nxt_path;
    logic [1:0] conv_cnt_ff;
    logic [1:0] nxt_conv_cnt;
    logic overrun_ff;
    logic nxt_overrun;
    int ratio_log2;
    int s3_log2;
    int post_log2;
    logic [CNT_W:0] ratio_n;
    logic [CNT_W:0] s3_n;
    logic [CNT_W-1:0] ratio_m1;
    logic [CNT_W-1:0] s3_mask;
    logic mod_en;
    logic clear;
    logic s3_dump;
    logic conv;
    logic [DATA_W-1:0] s3_norm;
    logic [DATA_W-1:0] f_norm;
    logic [DATA_W-1:0] p_norm;
    logic [DATA_W:0] push_word;
    logic fifo_in_ready;
    logic [DATA_W:0] fifo_out;

    always_comb begin
        // Ratio is 2**(7 + code).
        ratio_log2 = sdf_pkg::RATIO_MIN_LOG2 + int'(sel_ff);
        s3_log2 = (ratio_log2 > sdf_pkg::S3_MAX_LOG2) ? sdf_pkg::S3_MAX_LOG2 : ratio_log2;
        post_log2 = ratio_log2 - s3_log2;
        ratio_n = (CNT_W+1)'(1) << ratio_log2;
        s3_n = (CNT_W+1)'(1) << s3_log2;
        ratio_m1 = CNT_W'(ratio_n - 1'b1);
        s3_mask = CNT_W'(s3_n - 1'b1);
        nxt_div = (div_ff == DIV_W'(sdf_pkg::MOD_DIV - 1)) ? '0 : DIV_W'(div_ff + 1'b1);
        mod_en = div_ff == DIV_W'(sdf_pkg::MOD_DIV - 1);
        // Any of these events throws away the filter history and the conversion due in that cycle.
        clear = restart || (rate_ratio_sel != sel_ff);
        conv = mod_en && !clear && (ncnt_ff == ratio_m1);
        s3_dump = mod_en && ((ncnt_ff & s3_mask) == s3_mask);
        x = {{(ACC_W-1){1'b0}}, mod_bitstream};
        // Integrators and combs wrap modulo 2**32; the cube of 1024 still fits.
        c1 = i3_ff - d1_ff;
        c2 = c1 - d2_ff;
        c3 = c2 - d3_ff;
        s3_norm = DATA_W'({c3, sdf_pkg::FRAC_W'(0)} >> (3 * s3_log2));
        psum = PST_W'(pacc_ff + PST_W'(s3_norm));
        p_norm = DATA_W'(psum >> post_log2);
        fsum_tot = (CNT_W+1)'(fsum_ff + (CNT_W+1)'(mod_bitstream));
        f_norm = DATA_W'({fsum_tot, sdf_pkg::FRAC_W'(0)} >> ratio_log2);
        push_word = (path_ff == sdf_pkg::SDF_FAST) ? {1'b1, f_norm} : {1'b0, p_norm};
        nxt_ncnt = ncnt_ff;
        nxt_i1 = i1_ff;
        nxt_i2 = i2_ff;
        nxt_i3 = i3_ff;
        nxt_d1 = d1_ff;
        nxt_d2 = d2_ff;
        nxt_d3 = d3_ff;
        nxt_fsum = fsum_ff;
        nxt_pacc = pacc_ff;
        if (clear) begin
            nxt_ncnt = '0;
            nxt_i1 = '0;
            nxt_i2 = '0;
            nxt_i3 = '0;
            nxt_d1 = '0;
            nxt_d2 = '0;
            nxt_d3 = '0;
            nxt_fsum = '0;
            nxt_pacc = '0;
        end else if (mod_en) begin
            nxt_ncnt = conv ? '0 : CNT_W'(ncnt_ff + 1'b1);
            nxt_i1 = i1_ff + x;
            nxt_i2 = i2_ff + i1_ff;
            nxt_i3 = i3_ff + i2_ff;
            nxt_fsum = conv ? '0 : fsum_tot;
            if (s3_dump) begin
                nxt_d1 = i3_ff;
                nxt_d2 = c1;
                nxt_d3 = c2;
                nxt_pacc = conv ? '0 : psum;
            end
        end
        nxt_path = path_ff;
        nxt_conv_cnt = conv_cnt_ff;
        case (path_ff)
            sdf_pkg::SDF_FAST: begin
                if (conv) begin
                    nxt_conv_cnt = 2'(conv_cnt_ff + 1'b1);
                    if (nxt_conv_cnt == 2'(sdf_pkg::FAST_CONVS)) begin
                        nxt_path = sdf_pkg::SDF_SINC3;
                    end
                end
            end
            default: begin
                nxt_path = sdf_pkg::SDF_SINC3;
            end
        endcase
        nxt_overrun = conv && !fifo_in_ready;
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            div_ff <= '0;
            sel_ff <= sdf_pkg::SEL_RST;
            ncnt_ff <= '0;
            i1_ff <= '0;
            i2_ff <= '0;
            i3_ff <= '0;
            d1_ff <= '0;
            d2_ff <= '0;
            d3_ff <= '0;
            fsum_ff <= '0;
            pacc_ff <= '0;
            path_ff <= sdf_pkg::SDF_FAST;
            conv_cnt_ff <= sdf_pkg::CONV_CNT_RST;
            overrun_ff <= 1'b0;
        end else begin
            div_ff <= nxt_div;
            sel_ff <= rate_ratio_sel;
            ncnt_ff <= nxt_ncnt;
            i1_ff <= nxt_i1;
            i2_ff <= nxt_i2;
            i3_ff <= nxt_i3;
            d1_ff <= nxt_d1;
            d2_ff <= nxt_d2;
            d3_ff <= nxt_d3;
            fsum_ff <= nxt_fsum;
            pacc_ff <= nxt_pacc;
            path_ff <= nxt_path;
            conv_cnt_ff <= nxt_conv_cnt;
            overrun_ff <= nxt_overrun;
        end
    end

    // Every conversion is queued whether settled or not; a full queue drops it.
    sdf_fifo #(
        .WIDTH(DATA_W + 1),
        .DEPTH(sdf_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clock(clock),
        .srst(srst),
        .in_valid(conv),
        .in_ready(fifo_in_ready),
        .in_data(push_word),
        .out_valid(result_valid),
        .out_ready(result_ready),
        .out_data(fifo_out)
    );

    assign result_data = fifo_out[DATA_W-1:0];
    assign result_fast = fifo_out[DATA_W];
    assign data_ready_n = !result_valid;
    assign mod_clk_en = mod_en;
    assign overrun = overrun_ff;

    // Helper logic for the assertions below.
    logic [CNT_W+1:0] gap_ff;
    logic seen_ff;
    always_ff @(posedge clock) begin
        if (srst || clear) begin
            gap_ff <= '0;
            seen_ff <= 1'b0;
        end else begin
            gap_ff <= conv ? '0 : (CNT_W+2)'(gap_ff + 1'b1);
            seen_ff <= seen_ff || conv;
        end
    end

    mod_rate_a: assert property (@(posedge clock) disable iff (srst) mod_en |=> !mod_en ##1 mod_en)
        else $error("modulator enable is not every second clock");
    out_rate_a: assert property (@(posedge clock) disable iff (srst)
        (conv && seen_ff) |-> (gap_ff == (CNT_W+2)'(ratio_n * 2 - 1)))
        else $error("conversion spacing differs from ratio times two clocks");
    ratio_map_a: assert property (@(posedge clock) disable iff (srst)
        ratio_n == ((CNT_W+1)'(128) << sel_ff))
        else $error("ratio does not follow the select code");
    fast_first_a: assert property (@(posedge clock) disable iff (srst)
        (conv && conv_cnt_ff < 2'(sdf_pkg::FAST_CONVS)) |-> push_word[DATA_W])
        else $error("early conversion not from the fast path");
    sinc3_after_a: assert property (@(posedge clock) disable iff (srst)
        (conv && conv_cnt_ff == 2'(sdf_pkg::FAST_CONVS - 1)) |=> (path_ff == sdf_pkg::SDF_SINC3) [*3])
        else $error("third-order path left after two conversions");
    s3_fixed_a: assert property (@(posedge clock) disable iff (srst)
        (s3_dump && sel_ff > 3'h3) |-> (ncnt_ff[9:0] == 10'h3ff))
        else $error("third-order stage not decimating by 1024");
    conv_signal_a: assert property (@(posedge clock) disable iff (srst)
        (conv && fifo_in_ready) |=> !data_ready_n)
        else $error("conversion not signalled");
    restart_clr_a: assert property (@(posedge clock) disable iff (srst)
        restart |=> (ncnt_ff == '0 && i3_ff == '0 && fsum_ff == '0))
        else $error("restart did not clear filter history");
endmodule

`default_nettype wire

// ---- verif/sdf_host.sv ----
/*
 * Host model that drains filter results and judges settling for each word.
 * Assumes the filter's clock and reset; stall, restart and sel come from the bench.
 */
`timescale 1ns/100ps
`default_nettype none
module sdf_host (
    input wire logic clock,
    input wire logic srst,
    input wire logic stall,
    input wire logic restart,
    input wire logic [sdf_pkg::SEL_W-1:0] sel,
    input wire logic result_valid,
    input wire logic [sdf_pkg::DATA_W-1:0] result_data,
    input wire logic result_fast,
    output logic result_ready
);
    logic [sdf_pkg::DATA_W-1:0] q_data [$];
    logic q_fast [$];
    logic q_ok [$];
    int q_time [$];
    int cyc = 0;
    int since = 0;
    initial result_ready = 1'b0;
    always @(posedge clock) begin
        cyc <= cyc + 1;
        since <= (srst || restart) ? 0 : since + 1;
        result_ready <= !stall;
        if (result_valid === 1'b1 && result_ready === 1'b1) begin
            q_data.push_back(result_data);
            q_fast.push_back(result_fast);
            q_time.push_back(cyc);
            // A word is trusted only if it arrived after the interval ran out.
            q_ok.push_back(since > 2 * sdf_pkg::SETTLE_MOD[sel]);
        end
    end
endmodule
`default_nettype wire

// ---- verif/test_sdf_filter.sv ----
/*
 * Self-checking bench for the decimation filter, drained by the host model.
 * Assumes the package, the filter and the host model are compiled first.
 */
`timescale 1ns/100ps
`default_nettype none
module test_sdf_filter;
    localparam int ONE = 1 << sdf_pkg::FRAC_W;
    logic clock = 1'b0;
    logic srst = 1'b1;
    logic mod_bitstream = 1'b1;
    logic [sdf_pkg::SEL_W-1:0] rate_ratio_sel = 3'h0;
    logic restart = 1'b0;
    logic stall = 1'b0;
    logic mod_clk_en, result_fast, result_valid, result_ready, data_ready_n, overrun;
    logic [sdf_pkg::DATA_W-1:0] result_data;
    int n_errors = 0;
    int num_checks = 0;
    int base = 0;
    sdf_filter uut (.clock(clock), .srst(srst), .mod_bitstream(mod_bitstream), .rate_ratio_sel(rate_ratio_sel),
        .restart(restart), .mod_clk_en(mod_clk_en), .result_data(result_data), .result_fast(result_fast),
        .result_valid(result_valid), .result_ready(result_ready), .data_ready_n(data_ready_n), .overrun(overrun));
    sdf_host host (.clock(clock), .srst(srst), .stall(stall), .restart(restart), .sel(rate_ratio_sel),
        .result_valid(result_valid), .result_data(result_data), .result_fast(result_fast),
        .result_ready(result_ready));
    initial begin
        forever #25 clock = ~clock;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch at %0t: saw %0h, expected %0h", $time, seen, exp);
        end
    endtask
    task automatic wait_words(input int n);
        int t;
        t = 0;
        while (host.q_data.size() < base + n && t < 70000) begin
            @(posedge clock);
            t++;
        end
        check(32'(host.q_data.size() >= base + n), 32'h1);
    endtask
    task automatic do_restart(input logic [2:0] sel, input logic bit_val);
        @(posedge clock);
        rate_ratio_sel <= sel;
        mod_bitstream <= bit_val;
        restart <= 1'b1;
        @(posedge clock);
        restart <= 1'b0;
        #1;
        base = host.q_data.size();
    endtask
    task automatic t_reset_paths();
        int cnt;
        cnt = 0;
        repeat (100) begin
            @(posedge clock);
            #1;
            cnt += int'(mod_clk_en);
        end
        check(32'(cnt), 32'h32);
        wait_words(5);
        check(32'(host.q_data[0]), ONE);
        for (int i = 0; i < 5; i++) begin
            if (i < sdf_pkg::FAST_CONVS) check(32'(host.q_fast[i]), 32'h1);
            else check(32'(host.q_fast[i]), 32'h0);
        end
        check(32'(host.q_ok[4]), 32'h1);
        check(32'(host.q_data[4]), ONE);
    endtask
    task automatic t_settle();
        do_restart(3'h0, 1'b0);
        wait_words(6);
        for (int i = 0; i < 6; i++) begin
            check(32'(host.q_fast[base + i]), 32'h0);
        end
        check(32'(host.q_ok[base]), 32'h0);
        check(32'(host.q_ok[base + 5]), 32'h1);
        check(32'(host.q_data[base + 5]), 32'h0);
    endtask
    // Codes 6 and 7 are left out: two conversions at code 7 would not fit the run, though two at code 6 would.
    task automatic t_ratios();
        int k;
        for (int c = 0; c < 6; c++) begin
            k = (c < 5) ? 5 : 2;
            do_restart(3'(c), 1'b1);
            wait_words(k);
            check(32'(host.q_time[base + 1] - host.q_time[base]), 32'(256 << c));
            if (c < 5) begin
                check(32'(host.q_ok[base + 4]), 32'h1);
                if (c < 4) check(32'(host.q_data[base + 4]), ONE);
                else check(32'(host.q_data[base + 4]), ONE);
            end
        end
    endtask
    task automatic t_overrun();
        int cnt;
        cnt = 0;
        @(posedge clock);
        stall <= 1'b1;
        do_restart(3'h0, 1'b1);
        repeat (2350) begin
            @(posedge clock);
            #1;
            cnt += int'(overrun);
        end
        check(32'(cnt), 32'h1);
        check(32'(data_ready_n), 32'h0);
        @(posedge clock);
        stall <= 1'b0;
        repeat (20) @(posedge clock);
        #1;
        check(32'(host.q_data.size() - base), 32'h8);
        check(32'(data_ready_n), 32'h1);
    endtask
    task automatic close_out();
        $display("checks %0d, mismatches %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge clock);
        srst <= 1'b0;
        t_reset_paths();
        $display("reset paths done");
        t_settle();
        $display("settling done");
        t_ratios();
        $display("ratios done");
        t_overrun();
        $display("overrun done");
        close_out();
    end
    initial begin
        repeat (100000) @(posedge clock);
        n_errors++;
        close_out();
    end
endmodule
`default_nettype wire
